// file: src/adaptive_spike_clamp_filter.sv
// holds the sample fifo, one spike clamp channel and the two-channel top
// assumes the measurement path gives samples with valid/ready, synchronous to clock_i
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// small fifo with valid and ready on both sides
// ----------------------------------------------------------------------
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   // step a pointer, wrapping after the last slot
   function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
      next_ptr = (p == PTR_LAST) ? '0 : p + PTR_ONE;
   endfunction : next_ptr

   logic [WIDTH-1:0] mem_q [DEPTH];   // storage words
   logic [PTR_W-1:0] wr_ptr_q;        // next slot to write
   logic [PTR_W-1:0] wr_ptr_d;
   logic [PTR_W-1:0] rd_ptr_q;        // oldest word
   logic [PTR_W-1:0] rd_ptr_d;
   logic [CNT_W-1:0] count_q;         // words held
   logic [CNT_W-1:0] count_d;
   logic             in_ready_q;      // room for a word, kept in a flop
   logic             in_ready_d;
   logic             push;
   logic             pop;

   // ready straight from its flop, valid from the count
   assign in_ready_o  = in_ready_q;
   assign out_valid_o = (count_q != '0);
   assign out_data_o  = mem_q[rd_ptr_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // pointer and count next values
   always_comb begin
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      count_d  = count_q;
      if (push) begin
         wr_ptr_d = next_ptr(wr_ptr_q);
      end
      if (pop) begin
         rd_ptr_d = next_ptr(rd_ptr_q);
      end
      if (push && !pop) begin
         count_d = count_q + CNT_ONE;
      end else if (pop && !push) begin
         count_d = count_q - CNT_ONE;
      end
      // ready follows the next count, so the pin is a flop
      in_ready_d = (count_d != CNT_FULL);
   end

   // pointer and count registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
         in_ready_q <= 1'b1;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_d;
         in_ready_q <= in_ready_d;
      end
   end

   // storage words, written only on push
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end
endmodule : sample_fifo

// ----------------------------------------------------------------------
// one spike clamp channel: fifo then registered clamp stage
// ----------------------------------------------------------------------
module spike_clamp_channel
   import spike_clamp_pkg::*;
(
   input  wire logic                    clock_i,
   input  wire logic                    rst_n_i,
   input  wire logic                    in_valid_i,
   output logic                         in_ready_o,
   input  wire spike_clamp_pkg::sample_t in_sample_i,
   input  wire spike_clamp_pkg::band_t   band_i,
   input  wire logic                    band_off_i,
   output logic                         out_valid_o,
   input  wire logic                    out_ready_i,
   output spike_clamp_pkg::sample_t     out_sample_o,
   output logic                         clamped_o
);
   import spike_clamp_pkg::*;

   // saturate a wide signed value into the sample range
   function automatic sample_t sat_sample(input logic signed [DIFF_W-1:0] v);
      if (v > $signed(POS_LIMIT)) begin
         sat_sample = sample_t'($signed(POS_LIMIT));
      end else if (v < $signed(NEG_LIMIT)) begin
         sat_sample = sample_t'($signed(NEG_LIMIT));
      end else begin
         sat_sample = v[SAMPLE_W-1:0];
      end
   endfunction : sat_sample

   // sign-extend a sample to the wide width
   function automatic logic signed [DIFF_W-1:0] widen(input sample_t s);
      widen = {{(DIFF_W-SAMPLE_W){s[SAMPLE_W-1]}}, s};
   endfunction : widen

   // double the working band, pinned at the largest band
   function automatic band_t double_band(input band_t b);
      double_band = b[BAND_W-1] ? BAND_MAX : {b[BAND_W-2:0], 1'b0};
   endfunction : double_band

   logic       fifo_valid;          // buffered sample present
   sample_t    fifo_sample;         // buffered sample
   logic       stage_ready;         // clamp stage can take one
   logic       take;                // sample consumed this cycle

   sample_t    prev_q;              // previous output sample, after any clamp
   sample_t    prev_d;
   band_t      wband_q;             // working band
   band_t      wband_d;
   band_t      cfg_q;               // band setting last seen
   band_t      cfg_d;
   logic       off_q;               // off setting last seen
   logic       off_d;
   logic       first_q;             // next sample seeds prev
   logic       first_d;
   logic       out_valid_q;         // output holds a sample
   logic       out_valid_d;
   sample_t    out_q;               // output sample
   sample_t    out_d;
   logic       clamped_q;           // output sample was clamped
   logic       clamped_d;

   logic signed [DIFF_W-1:0] diff;   // new minus previous
   logic signed [DIFF_W-1:0] band_w; // working band, wide
   logic                     cfg_change;

   // input buffer; its ready is the channel's back-pressure
   sample_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (in_valid_i),
      .in_ready_o  (in_ready_o),
      .in_data_i   (in_sample_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (stage_ready),
      .out_data_o  (fifo_sample)
   );

   assign stage_ready = ~out_valid_q | out_ready_i;
   assign take        = fifo_valid & stage_ready;
   assign diff        = widen(fifo_sample) - widen(prev_q);
   assign band_w      = {{(DIFF_W-BAND_W){1'b0}}, wband_q};
   assign cfg_change  = (band_i != cfg_q) || (band_off_i != off_q);

   // clamp stage next values
   always_comb begin
      prev_d      = prev_q;
      wband_d     = wband_q;
      cfg_d       = band_i;
      off_d       = band_off_i;
      first_d     = first_q;
      out_valid_d = out_valid_q & ~out_ready_i;
      out_d       = out_q;
      clamped_d   = clamped_q;
      // (R08) reload band on change
      if (cfg_change) begin
         wband_d = band_i;
         first_d = 1'b1;
      end
      if (take) begin
         out_valid_d = 1'b1;
         clamped_d   = 1'b0;
         out_d       = fifo_sample;
         if (band_off_i) begin
            // (R07) off means pass through
            out_d   = fifo_sample;
            first_d = 1'b1;
         end else if (first_q || cfg_change) begin
            // (R08) seed without clamping
            out_d   = fifo_sample;
            wband_d = band_i;
            first_d = 1'b0;
         end else if (diff > band_w) begin
            // (R03) band compared to difference
            // (R04) clamp upward jump
            out_d     = sat_sample(widen(prev_q) + band_w);
            clamped_d = 1'b1;
            // (R05) double working band
            wband_d   = double_band(wband_q);
         end else if (diff < -band_w) begin
            // (R04) clamp downward jump
            out_d     = sat_sample(widen(prev_q) - band_w);
            clamped_d = 1'b1;
            // (R05) double working band
            wband_d   = double_band(wband_q);
         end else begin
            // (R06) restore original band
            out_d   = fifo_sample;
            wband_d = cfg_q;
         end
         // (R02) limit move from previous output sample
         prev_d = out_d;
      end
   end

   // clamp stage registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q      <= SAMPLE_RST;
         wband_q     <= BAND_RST;
         cfg_q       <= BAND_RST;
         off_q       <= 1'b0;
         first_q     <= 1'b1;
         out_valid_q <= 1'b0;
         out_q       <= SAMPLE_RST;
         clamped_q   <= 1'b0;
      end else begin
         prev_q      <= prev_d;
         wband_q     <= wband_d;
         cfg_q       <= cfg_d;
         off_q       <= off_d;
         first_q     <= first_d;
         out_valid_q <= out_valid_d;
         out_q       <= out_d;
         clamped_q   <= clamped_d;
      end
   end

   assign out_valid_o  = out_valid_q;
   assign out_sample_o = out_q;
   assign clamped_o    = clamped_q;
endmodule : spike_clamp_channel

// ----------------------------------------------------------------------
// two-channel top
// ----------------------------------------------------------------------
// Operation
// (R01) separate filter and band per input
// (R02) limit each sample's move from previous
// (R03) band in measured units, compared directly
// (R04) too-large jump clamps to previous plus/minus band
// (R05) every clamp doubles the working band
// (R06) in-band sample restores configured band
// (R07) band off skips the clamp; samples still pass through the registered stage, unclamped
// (R08) reset or band change reloads, seeds unclamped
module adaptive_spike_clamp_filter
   import spike_clamp_pkg::*;
(
   input  wire logic                    clock_i,
   input  wire logic                    rst_n_i,
   input  wire logic                    ch0_in_valid_i,
   output logic                         ch0_in_ready_o,
   input  wire spike_clamp_pkg::sample_t ch0_in_sample_i,
   input  wire spike_clamp_pkg::band_t   ch0_band_i,
   input  wire logic                    ch0_band_off_i,
   output logic                         ch0_out_valid_o,
   input  wire logic                    ch0_out_ready_i,
   output spike_clamp_pkg::sample_t     ch0_out_sample_o,
   output logic                         ch0_clamped_o,
   input  wire logic                    ch1_in_valid_i,
   output logic                         ch1_in_ready_o,
   input  wire spike_clamp_pkg::sample_t ch1_in_sample_i,
   input  wire spike_clamp_pkg::band_t   ch1_band_i,
   input  wire logic                    ch1_band_off_i,
   output logic                         ch1_out_valid_o,
   input  wire logic                    ch1_out_ready_i,
   output spike_clamp_pkg::sample_t     ch1_out_sample_o,
   output logic                         ch1_clamped_o
);
   import spike_clamp_pkg::*;

   // (R01) channel 0 stage
   spike_clamp_channel u_ch0 (
      .clock_i      (clock_i),
      .rst_n_i      (rst_n_i),
      .in_valid_i   (ch0_in_valid_i),
      .in_ready_o   (ch0_in_ready_o),
      .in_sample_i  (ch0_in_sample_i),
      .band_i       (ch0_band_i),
      .band_off_i   (ch0_band_off_i),
      .out_valid_o  (ch0_out_valid_o),
      .out_ready_i  (ch0_out_ready_i),
      .out_sample_o (ch0_out_sample_o),
      .clamped_o    (ch0_clamped_o)
   );

   // (R01) channel 1 stage
   spike_clamp_channel u_ch1 (
      .clock_i      (clock_i),
      .rst_n_i      (rst_n_i),
      .in_valid_i   (ch1_in_valid_i),
      .in_ready_o   (ch1_in_ready_o),
      .in_sample_i  (ch1_in_sample_i),
      .band_i       (ch1_band_i),
      .band_off_i   (ch1_band_off_i),
      .out_valid_o  (ch1_out_valid_o),
      .out_ready_i  (ch1_out_ready_i),
      .out_sample_o (ch1_out_sample_o),
      .clamped_o    (ch1_clamped_o)
   );
endmodule : adaptive_spike_clamp_filter

`default_nettype wire

// file: src/spike_clamp_pkg.sv
// holds widths, depths and reset values shared by the spike clamp design
// assumes samples and band settings are in the same units of the measured value
package spike_clamp_pkg;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int SAMPLE_W = 16;              // signed sample width
   localparam int BAND_W   = 16;              // unsigned band width
   localparam int DIFF_W   = SAMPLE_W + 2;    // room for difference and sums

   // ------------------------------------------------------------------
   // buffering
   // ------------------------------------------------------------------
   localparam int FIFO_DEPTH = 4;             // words ahead of each filter

   // ------------------------------------------------------------------
   // reset values and limits
   // ------------------------------------------------------------------
   localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;
   localparam logic [BAND_W-1:0]   BAND_RST   = 16'h0000;
   localparam logic [BAND_W-1:0]   BAND_MAX   = 16'hFFFF;
   localparam logic [DIFF_W-1:0]   POS_LIMIT  = 18'h07FFF;
   localparam logic [DIFF_W-1:0]   NEG_LIMIT  = 18'h38000;

   typedef logic signed [SAMPLE_W-1:0] sample_t;
   typedef logic        [BAND_W-1:0]   band_t;

endpackage : spike_clamp_pkg

// file: src/empty_placeholder_removed.sv
// intentionally empty file holder for build ordering; holds no logic
// assumes nothing of its surroundings

// file: tb/sample_source.sv
// sample source model for one measurement input
// assumes the bench hands samples over through push()
`timescale 1ns/100ps
`default_nettype none
module sample_source
   import spike_clamp_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic slow_i,
   input  wire logic ready_i,
   output var  logic valid_o,
   output var  spike_clamp_pkg::sample_t sample_o
);
   sample_t q [$];          // samples not yet taken
   logic    took = 1'b0;    // offer taken at last edge
   initial valid_o = 1'b0;
   initial sample_o = 16'h0000;
   always @(posedge clock_i) took = valid_o && ready_i;
   // hold each offer until taken; idle data inverts every cycle
   always @(negedge clock_i) begin
      if (took) void'(q.pop_front());
      if (rst_n_i && q.size() > 0 && !(took && slow_i)) begin
         valid_o <= 1'b1;
         sample_o <= q[0];
      end else begin
         valid_o <= 1'b0;
         sample_o <= ~sample_o;
      end
   end
   task push(input sample_t s);
      q.push_back(s);
   endtask : push
endmodule : sample_source
`default_nettype wire

// file: tb/spike_clamp_asserts.sv
// port assertions for the two-channel spike clamp
// assumes it is bound into adaptive_spike_clamp_filter
`timescale 1ns/100ps
`default_nettype none
module spike_clamp_asserts
   import spike_clamp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ch0_in_valid_i,
   input wire logic ch0_in_ready_o,
   input wire spike_clamp_pkg::band_t ch0_band_i,
   input wire logic ch0_band_off_i,
   input wire logic ch0_out_valid_o,
   input wire logic ch0_out_ready_i,
   input wire spike_clamp_pkg::sample_t ch0_out_sample_o,
   input wire logic ch0_clamped_o,
   input wire logic ch1_out_valid_o,
   input wire logic ch1_out_ready_i,
   input wire spike_clamp_pkg::sample_t ch1_out_sample_o,
   input wire logic ch1_clamped_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic    hold_q, cl_q, new0;           // stalled, last clamped, fresh
   sample_t last_q;                       // last output taken
   logic signed [DIFF_W-1:0] d, pd_q, ad, apd;   // steps and sizes
   assign new0 = ch0_out_valid_o && !hold_q;
   assign d = ch0_out_sample_o - last_q;
   assign ad = (d < 0) ? -d : d;
   assign apd = (pd_q < 0) ? -pd_q : pd_q;
   // remember the last taken output and its step
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_q <= 1'b0;
         cl_q <= 1'b0;
         last_q <= '0;
         pd_q <= '0;
      end else begin
         hold_q <= ch0_out_valid_o && !ch0_out_ready_i;
         if (ch0_out_valid_o && ch0_out_ready_i) begin
            cl_q <= ch0_clamped_o;
            last_q <= ch0_out_sample_o;
            pd_q <= d;
         end
      end
   end
   sequence cfg_steady;
      ($stable(ch0_band_i) && !ch0_band_off_i) [*4];
   endsequence
   sequence fresh_clamp;
      new0 && ch0_clamped_o;
   endsequence
   a_out_hold: assert property (ch0_out_valid_o && !ch0_out_ready_i |=> ch0_out_valid_o
      && $stable(ch0_out_sample_o) && $stable(ch0_clamped_o)) else $error("ch0 output moved");
   a_hold_ch1: assert property (
      ch1_out_valid_o && !ch1_out_ready_i |=> ch1_out_valid_o && $stable(ch1_out_sample_o)
      && $stable(ch1_clamped_o)) else $error("ch1 output moved");
   a_bypass_pass: assert property (
      new0 && $past(ch0_band_off_i) |-> !ch0_clamped_o) else $error("bypass clamped");
   a_clamp_step: assert property (
      cfg_steady ##0 fresh_clamp |-> ad == (cl_q ? 2 * apd : ch0_band_i))
      else $error("clamp step wrong");
   a_full_holds: assert property (!ch0_in_ready_o && ch0_out_valid_o && !ch0_out_ready_i
      |=> !ch0_in_ready_o) else $error("ready rose while stalled");
   a_full_valid: assert property (!ch0_in_ready_o |-> ch0_out_valid_o)
      else $error("full with empty output");
   a_take_answer: assert property (
      ch0_in_valid_i && ch0_in_ready_o |-> ##[1:3] ch0_out_valid_o) else $error("no output");
   a_reset_idle: assert property (
      !$past(rst_n_i) |-> ch0_in_ready_o && !ch0_out_valid_o && !ch0_clamped_o)
      else $error("not idle after reset");
endmodule : spike_clamp_asserts
bind adaptive_spike_clamp_filter spike_clamp_asserts spike_clamp_asserts_i (.*);
`default_nettype wire

// file: tb/adaptive_spike_clamp_filter_tb.sv
// self-checking bench for the two-channel spike clamp
// assumes sample_source models feed both inputs
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module adaptive_spike_clamp_filter_tb;
   import spike_clamp_pkg::*;
   logic clock_i, rst_n_i;              // clock and reset
   logic [1:0] off, ordy, slow;         // bench controls
   logic vld [2], rdy [2], ovld [2], cl [2];   // handshakes
   band_t band [2];                     // band per channel
   sample_t smp [2], osmp [2];          // samples in and out
   int fails, checks, p [2], w [2];     // counters, reference
   bit first [2];                       // seed pending
   logic [16:0] got [2][$], exp [2][$]; // clamped and sample
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   for (genvar g = 0; g < 2; g++) begin : src
      sample_source sample_source_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
         .slow_i(slow[g]), .ready_i(rdy[g]), .valid_o(vld[g]), .sample_o(smp[g]));
   end
   adaptive_spike_clamp_filter adaptive_spike_clamp_filter_i (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ch0_in_valid_i(vld[0]),
      .ch0_in_ready_o(rdy[0]), .ch0_in_sample_i(smp[0]), .ch0_band_i(band[0]),
      .ch0_band_off_i(off[0]), .ch0_out_valid_o(ovld[0]), .ch0_out_ready_i(ordy[0]),
      .ch0_out_sample_o(osmp[0]), .ch0_clamped_o(cl[0]), .ch1_in_valid_i(vld[1]),
      .ch1_in_ready_o(rdy[1]), .ch1_in_sample_i(smp[1]), .ch1_band_i(band[1]),
      .ch1_band_off_i(off[1]), .ch1_out_valid_o(ovld[1]), .ch1_out_ready_i(ordy[1]),
      .ch1_out_sample_o(osmp[1]), .ch1_clamped_o(cl[1]));
   // record every output the sink takes
   always @(posedge clock_i)
      for (int c = 0; c < 2; c++)
         if (ovld[c] && ordy[c]) got[c].push_back({cl[c], osmp[c]});
   function automatic logic [15:0] sat(input int v);
      return (v > 32767) ? 16'h7FFF : (v < -32768) ? 16'h8000 : v[15:0];
   endfunction : sat
   // new band or bypass; next sample seeds
   task automatic cfg(input int ch, input int b, input logic o);
      @(negedge clock_i);
      band[ch] = band_t'(b);
      off[ch] = o;
      first[ch] = 1'b1;
   endtask : cfg
   // reference step, then offer the sample
   task automatic send(input int ch, input int s);
      int d;
      logic [16:0] e;
      d = s - p[ch];
      e = {1'b0, sat(s)};
      if (off[ch]) first[ch] = 1'b1;
      else if (first[ch]) begin
         first[ch] = 1'b0;
         w[ch] = band[ch];
      end else if (d > w[ch] || d < -w[ch]) begin
         e = {1'b1, sat((d > 0) ? p[ch] + w[ch] : p[ch] - w[ch])};
         w[ch] = (w[ch] > 32767) ? 65535 : 2 * w[ch];
      end else w[ch] = band[ch];
      p[ch] = $signed(e[15:0]);
      exp[ch].push_back(e);
      if (ch == 0) src[0].sample_source_i.push(sample_t'(s));
      else src[1].sample_source_i.push(sample_t'(s));
   endtask : send
   // wait for all outputs, then compare in order
   task automatic drain(input int ch);
      int n;
      logic [16:0] a, b;
      n = 0;
      while (got[ch].size() < exp[ch].size() && n < 300) begin
         @(negedge clock_i);
         n++;
      end
      repeat (4) @(negedge clock_i);
      `CHK(got[ch].size(), exp[ch].size())
      while (got[ch].size() > 0 && exp[ch].size() > 0) begin
         a = got[ch].pop_front();
         b = exp[ch].pop_front();
         `CHK(a, b)
      end
      exp[ch].delete();
   endtask : drain
   task automatic t_clamp;
      int v [7] = '{0, 5, 30, 50, 40, 60, -100};
      foreach (v[i]) send(0, v[i]);
      drain(0);
      $display("t_clamp done");
   endtask : t_clamp
   task automatic t_bypass;
      int v [3] = '{0, 1000, -1000};
      cfg(0, 10, 1'b1);
      foreach (v[i]) send(0, v[i]);
      drain(0);
      cfg(0, 10, 1'b0);
      send(0, 500);
      send(0, 600);
      drain(0);
      $display("t_bypass done");
   endtask : t_bypass
   task automatic t_bandchg;
      cfg(0, 20, 1'b0);
      send(0, 0);
      send(0, 100);
      drain(0);
      cfg(0, 30, 1'b0);
      send(0, 300);
      send(0, 340);
      drain(0);
      $display("t_bandchg done");
   endtask : t_bandchg
   // sink stalls until the buffer refuses
   task automatic t_stall;
      cfg(0, 10, 1'b0);
      ordy[0] = 1'b0;
      for (int i = 0; i < 8; i++) send(0, i);
      repeat (12) @(negedge clock_i);
      `CHK({rdy[0], rdy[1]}, 2'b01)
      ordy[0] = 1'b1;
      drain(0);
      $display("t_stall done");
   endtask : t_stall
   // same samples, different bands, slow source
   task automatic t_indep;
      cfg(0, 100, 1'b0);
      slow = 2'b11;
      ordy[1] = 1'b0;
      send(0, 0);
      send(1, 0);
      send(0, 50);
      send(1, 50);
      repeat (8) @(negedge clock_i);
      ordy[1] = 1'b1;
      drain(0);
      drain(1);
      $display("t_indep done");
   endtask : t_indep
   task finish_test;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      rst_n_i = 1'b0;
      {off, slow} = 4'h0;
      ordy = 2'b11;
      band[0] = 16'h000A;
      band[1] = 16'h0005;
      first = '{1'b1, 1'b1};
      repeat (10) @(negedge clock_i);
      rst_n_i = 1'b1;
      `CHK({rdy[0], rdy[1], ovld[0], ovld[1]}, 4'hC)
      t_clamp;
      t_bypass;
      t_bandchg;
      t_stall;
      t_indep;
      finish_test;
   end
   // watchdog well past the expected run
   initial begin
      #200000;
      fails++;
      finish_test;
   end
endmodule : adaptive_spike_clamp_filter_tb
`default_nettype wire
